/* deser_datapath_i2c_audio_regs.sv */
// configuration and status bank of the video link deserializer: bus clock
// timing, datapath mirror, audio serial control, pixel clock test, input mode
// assumes register requests, forward-channel loads and audio events come from
// logic on ref_clk; only the bus clock line arrives from a pin
//
// Operation
// RQ1: bus master holds clock high for high count times 50 ns; reset 83h.
// RQ2: bus master holds clock low for low count times 50 ns; reset 84h.
// RQ3: as slave, low count is data setup time before the stretched clock releases.
// RQ4: reset counts give at least 5 us per phase at 26 MHz.
// RQ5: datapath fields load from the remote serializer over the forward channel.
// RQ6: hold bit 7 blocks forward-channel loads and keeps local values.
// RQ7: bit 5 reports no active video; control channel and pins keep working.
// RQ8: bit 4 says two links; used to recover data in auto input mode.
// RQ9: bit 3 puts alternate audio on pin 1 (word clock) and pin 0 (data).
// RQ10: bit 2 disables the audio serial output.
// RQ11: bit 1 selects 28-bit video carrying sync and data enable.
// RQ12: bit 0 turns surround audio output on.
// RQ13: read-only overrun and underrun flags at bits 3, 2; writing bit 1 clears them.
// RQ14: audio bit 0 picks strobe edge: 1 rising, 0 falling.
// RQ15: pixel clock bit 7 takes pixel clock from the test clock input.
// RQ16: input mode field: auto, forced dual, forced primary, forced secondary.
// RQ17: reserved bits stay zero and do nothing; here input mode bit 0 reads one.
`timescale 1ns/10ps
`default_nettype none
`include "deser_regs_defines.svh"
module deser_datapath_i2c_audio_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire deser_regs_pkg::reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire deser_regs_pkg::fc_cfg_s fc_cfg,
    input wire logic [7:0] selftest_err_cnt,
    input wire logic master_en,
    input wire logic slave_setup_req,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    output logic slave_release,
    input wire logic audio_word_clk,
    input wire logic audio_data,
    input wire logic overrun_evt,
    input wire logic underrun_evt,
    output logic general_pin_0_o,
    output logic general_pin_0_oe,
    output logic general_pin_1_o,
    output logic general_pin_1_oe,
    output logic video_active,
    output logic sync_carrying_video_en,
    output logic audio_off,
    output logic surround_en,
    output logic audio_rising_edge,
    output logic pclk_from_test_clock_input,
    output logic rx_dual_link,
    output logic rx_use_secondary
);
    import deser_regs_pkg::*;

    typedef struct packed {
        logic [7:0] scl_high;
        logic [7:0] scl_low;
        logic [7:0] dpath;
        logic overrun;
        logic underrun;
        logic rise_edge;
        logic pclk_ext;
        logic [1:0] rx_mode;
        logic [7:0] rdata;
        scl_state_e scl_state;
        logic hi_started;
        logic stretch;
        logic release_p;
        logic scl_oe;
        logic rx_dual;
        logic rx_sec;
        logic pin0;
        logic pin1;
        logic pins_oe;
    } bank_s;
    bank_s st_r;
    bank_s st_nxt;

    logic scl_sync;
    logic m_start;
    logic m_expire;
    logic s_start;
    logic s_expire;
    phase_t m_len;
    phase_t high_cycles;
    phase_t low_cycles;

    // counts to cycles; widest product 255 * 10 fits 12 bits
    assign high_cycles = 12'(st_r.scl_high * `UNIT_CYCLES);
    assign low_cycles = 12'(st_r.scl_low * `UNIT_CYCLES);

    // bus clock line seen back, for clock synchronisation with other masters
    sync2 u_scl_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(scl_i),
        .q(scl_sync)
    );

    // master phase timer
    phase_timer u_master_tmr (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .start(m_start),
        .len(m_len),
        .busy(),
        .expire(m_expire)
    );

    // slave setup timer
    phase_timer u_slave_tmr (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .start(s_start),
        .len(low_cycles),
        .busy(),
        .expire(s_expire)
    );

    // timer starts: high phase starts once the line is really high, so a
    // slave stretching the clock lengthens the low phase, not the high one
    always_comb begin
        m_start = 1'b0;
        m_len = high_cycles;
        if (st_r.scl_state == SCL_HIGH && !st_r.hi_started && scl_sync) begin
            m_start = 1'b1;
        end else if (st_r.scl_state == SCL_HIGH && m_expire && master_en) begin
            m_start = 1'b1;
            m_len = low_cycles;
        end
        s_start = slave_setup_req && !st_r.stretch;
    end

    // register bank, flags, clock generator and pin muxing
    always_comb begin
        st_nxt = st_r;
        st_nxt.release_p = 1'b0;

        // RQ5 forward channel load
        // RQ6 hold blocks loads
        if (fc_cfg.load && !st_r.dpath[`DP_HOLD]) begin
            st_nxt.dpath[5:0] = fc_cfg.bits;
        end

        // local writes; a write in the same cycle as a load wins
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                // RQ1 high count
                `REG_SCL_HIGH: st_nxt.scl_high = reg_req.wdata;
                // RQ2 low count
                `REG_SCL_LOW: st_nxt.scl_low = reg_req.wdata;
                // RQ17 reserved bit dropped
                `REG_DPATH: st_nxt.dpath = reg_req.wdata & 8'hBF;
                `REG_AUDIO: st_nxt.rise_edge = reg_req.wdata[`AU_RISE_EDGE];
                `REG_PCLK: st_nxt.pclk_ext = reg_req.wdata[`PCLK_EXT];
                `REG_DUAL_RX: st_nxt.rx_mode = reg_req.wdata[`RX_MODE_HI:`RX_MODE_LO];
                default: st_nxt.rx_mode = st_nxt.rx_mode;
            endcase
        end

        // RQ13 error flags: set wins over clear
        if (reg_req.wr && reg_req.addr == `REG_AUDIO && reg_req.wdata[`AU_ERR_CLR]) begin
            st_nxt.overrun = 1'b0;
            st_nxt.underrun = 1'b0;
        end
        if (overrun_evt) begin
            st_nxt.overrun = 1'b1;
        end
        if (underrun_evt) begin
            st_nxt.underrun = 1'b1;
        end

        // read data; unmapped offsets read zero, reserved bits read zero except input mode bit 0, which reads one
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `REG_SELFTEST_ERR: st_nxt.rdata = selftest_err_cnt;
                `REG_SCL_HIGH: st_nxt.rdata = st_r.scl_high;
                `REG_SCL_LOW: st_nxt.rdata = st_r.scl_low;
                `REG_DPATH: st_nxt.rdata = st_r.dpath;
                `REG_AUDIO: st_nxt.rdata = {4'h0, st_r.overrun, st_r.underrun, 1'b0,
                                            st_r.rise_edge};
                `REG_PCLK: st_nxt.rdata = {st_r.pclk_ext, 7'h00};
                `REG_DUAL_RX: st_nxt.rdata = {3'h0, st_r.rx_mode, 2'h0, 1'b1};
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // RQ1 high phase
        // RQ2 low phase
        unique case (st_r.scl_state)
            SCL_IDLE: begin
                if (master_en) begin
                    st_nxt.scl_state = SCL_HIGH;
                    st_nxt.hi_started = 1'b0;
                end
            end
            SCL_HIGH: begin
                if (m_start && !st_r.hi_started) begin
                    st_nxt.hi_started = 1'b1;
                end else if (m_expire) begin
                    st_nxt.scl_state = master_en ? SCL_LOW : SCL_IDLE;
                end
            end
            SCL_LOW: begin
                if (m_expire) begin
                    st_nxt.scl_state = SCL_HIGH;
                    st_nxt.hi_started = 1'b0;
                end
            end
            default: st_nxt.scl_state = SCL_IDLE;
        endcase

        // RQ3 slave setup stretch
        if (s_start) begin
            st_nxt.stretch = 1'b1;
        end else if (s_expire) begin
            st_nxt.stretch = 1'b0;
            st_nxt.release_p = 1'b1;
        end
        st_nxt.scl_oe = (st_nxt.scl_state == SCL_LOW) || st_nxt.stretch;

        // RQ16 input mode
        // RQ8 link count in auto mode
        unique case (rx_mode_e'(st_r.rx_mode))
            RX_AUTO: begin
                st_nxt.rx_dual = st_r.dpath[`DP_DUAL_LINK];
                st_nxt.rx_sec = 1'b0;
            end
            RX_DUAL: begin
                st_nxt.rx_dual = 1'b1;
                st_nxt.rx_sec = 1'b0;
            end
            RX_PRIMARY: begin
                st_nxt.rx_dual = 1'b0;
                st_nxt.rx_sec = 1'b0;
            end
            RX_SECONDARY: begin
                st_nxt.rx_dual = 1'b0;
                st_nxt.rx_sec = 1'b1;
            end
        endcase

        // RQ9 alternate audio pins
        // RQ10 disable gates pins too
        st_nxt.pins_oe = st_r.dpath[`DP_ALT_AUDIO] && !st_r.dpath[`DP_AUDIO_OFF];
        st_nxt.pin1 = st_nxt.pins_oe && audio_word_clk;
        st_nxt.pin0 = st_nxt.pins_oe && audio_data;
    end

    // state register; counts come up at values with margin for a fast oscillator
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            // RQ4 reset margin
            st_r.scl_high <= `RST_SCL_HIGH;
            st_r.scl_low <= `RST_SCL_LOW;
            st_r.dpath <= `RST_DPATH;
            st_r.rx_mode <= 2'h0;
            st_r.scl_state <= SCL_IDLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops, scl_o tied low; the line is open drain
    assign reg_rdata = st_r.rdata;
    assign scl_o = 1'b0;
    assign scl_oe = st_r.scl_oe;
    assign slave_release = st_r.release_p;
    assign general_pin_0_o = st_r.pin0;
    assign general_pin_0_oe = st_r.pins_oe;
    assign general_pin_1_o = st_r.pin1;
    assign general_pin_1_oe = st_r.pins_oe;
    // RQ7 video off status; control channel is never gated by it
    assign video_active = !st_r.dpath[`DP_VIDEO_OFF];
    // RQ11 sync-carrying framing
    assign sync_carrying_video_en = st_r.dpath[`DP_SYNC_VIDEO];
    assign audio_off = st_r.dpath[`DP_AUDIO_OFF];
    // RQ12 surround enable
    assign surround_en = st_r.dpath[`DP_SURROUND];
    // RQ14 strobe edge
    assign audio_rising_edge = st_r.rise_edge;
    // RQ15 pixel clock source
    assign pclk_from_test_clock_input = st_r.pclk_ext;
    assign rx_dual_link = st_r.rx_dual;
    assign rx_use_secondary = st_r.rx_sec;

    // helper: cycles since the master timer was started
    phase_t phase_cnt_r;
    phase_t phase_len_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase_cnt_r <= 12'h000;
            phase_len_r <= 12'h000;
        end else if (ce) begin
            phase_cnt_r <= m_start ? 12'h000 : phase_cnt_r + 12'h001;
            phase_len_r <= m_start ? m_len : phase_len_r;
        end
    end

    a_phase_len: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ1
        ce && m_expire && phase_len_r != 12'h000 |-> phase_cnt_r == phase_len_r - 12'h001)
        else $error("bus clock phase length wrong");
    a_low_from_reg: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ2
        ce && m_start && st_r.scl_state == SCL_HIGH && st_r.hi_started
        |=> phase_len_r == $past(low_cycles) && scl_oe)
        else $error("low phase not loaded from low count");
    a_slave_stretch: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ3
        ce && s_start && ce ##1 ce |-> scl_oe ##1 (scl_oe || slave_release))
        else $error("slave setup stretch not held");
    a_reset_margin: assert property (@(posedge ref_clk) // RQ4
        $rose(rst_n) |-> st_r.scl_high == `RST_SCL_HIGH && st_r.scl_low == `RST_SCL_LOW
        && (int'(st_r.scl_high) * `UNIT_NS * `NOM_OSC_MHZ) / `FAST_OSC_MHZ >= `MIN_PHASE_NS)
        else $error("reset bus clock counts lack margin");
    a_fc_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ5
        ce && fc_cfg.load && !st_r.dpath[`DP_HOLD] && !reg_req.wr
        |=> st_r.dpath[5:0] == $past(fc_cfg.bits))
        else $error("forward channel load missed");
    a_hold_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ6
        ce && st_r.dpath[`DP_HOLD] && !reg_req.wr |=> $stable(st_r.dpath))
        else $error("held datapath config changed");
    a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ13
        ce && overrun_evt |=> st_r.overrun)
        else $error("overrun event lost");
    a_flag_readback: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ13
        ce && reg_req.rd && reg_req.addr == `REG_AUDIO
        |=> reg_rdata[`AU_OVERRUN] == $past(st_r.overrun)
        && reg_rdata[`AU_UNDERRUN] == $past(st_r.underrun))
        else $error("fifo error flags not readable");
    a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ13
        ce && reg_req.wr && reg_req.addr == `REG_AUDIO && reg_req.wdata[`AU_ERR_CLR]
        && !overrun_evt && !underrun_evt |=> !st_r.overrun && !st_r.underrun)
        else $error("fifo error flags not cleared");
    a_auto_mode: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ16
        ce && st_r.rx_mode == 2'h0
        |=> rx_dual_link == $past(st_r.dpath[`DP_DUAL_LINK]) && !rx_use_secondary)
        else $error("auto input mode ignores link count");
    a_alt_pins: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ9
        ce && st_r.dpath[`DP_ALT_AUDIO] && !st_r.dpath[`DP_AUDIO_OFF]
        |=> general_pin_1_oe && general_pin_1_o == $past(audio_word_clk)
        && general_pin_0_o == $past(audio_data))
        else $error("alternate audio not on general pins");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ17
        st_r.dpath[6] == 1'b0)
        else $error("reserved datapath bit set");
endmodule
`default_nettype wire

/* deser_datapath_i2c_audio_regs_tb.sv */
// self-checking bench for the deserializer configuration bank
// assumes remote_ser_model and the design files are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module deser_datapath_i2c_audio_regs_tb;
    import deser_regs_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_s reg_req = '0;
    fc_cfg_s fc_cfg;
    logic [7:0] reg_rdata, err_cnt = 8'hA5;
    logic master_en = 1'b0, setup_req = 1'b0, word_clk = 1'b0, adata = 1'b0;
    logic ovr = 1'b0, und = 1'b0, ce = 1'b1;
    logic scl_o, scl_oe, rel, p0_o, p0_oe, p1_o, p1_oe, vid, syncv, aoff, surr;
    logic rise, pclk_ext, dual, sec;
    wire logic scl_i;
    int n_errors = 0, cmp_count = 0, n, hi;
    logic [1:0] dual_exp [4] = '{2'b00, 2'b01, 2'b00, 2'b10};

    // open-drain line with a pull-up: high unless someone pulls it low
    assign scl_i = ~scl_oe;

    always #2.5 ref_clk = ~ref_clk;

    remote_ser_model remote_ser_model_inst (.ref_clk(ref_clk), .fc_cfg(fc_cfg));

    deser_datapath_i2c_audio_regs deser_datapath_i2c_audio_regs_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .fc_cfg(fc_cfg), .selftest_err_cnt(err_cnt),
        .master_en(master_en), .slave_setup_req(setup_req), .scl_i(scl_i),
        .scl_o(scl_o), .scl_oe(scl_oe), .slave_release(rel),
        .audio_word_clk(word_clk), .audio_data(adata), .overrun_evt(ovr),
        .underrun_evt(und), .general_pin_0_o(p0_o), .general_pin_0_oe(p0_oe),
        .general_pin_1_o(p1_o), .general_pin_1_oe(p1_oe), .video_active(vid),
        .sync_carrying_video_en(syncv), .audio_off(aoff), .surround_en(surr),
        .audio_rising_edge(rise), .pclk_from_test_clock_input(pclk_ext),
        .rx_dual_link(dual), .rx_use_secondary(sec)
    );

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // one-cycle request pulse, released a full cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        reg_req = {1'b1, 1'b0, a, d};
        cyc(1);
        reg_req = '0;
    endtask

    // read data is registered at the request edge, so it is checked just after
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cyc(1);
        reg_req = {1'b0, 1'b1, a, 8'h00};
        cyc(1);
        reg_req = '0;
        `CHK("read data", e, reg_rdata)
    endtask

    // counts cycles while scl_oe keeps level v, or until rel pulses when rel_sel is set, bounded
    task automatic span(input logic v, input logic rel_sel, output int k);
        k = 0;
        while ((rel_sel ? (rel !== 1'b1) : (scl_oe === v)) && k < 3000) begin
            cyc(1);
            k++;
        end
        if (k >= 3000) begin
            n_errors++;
            test_done();
        end
    endtask

    initial begin
        cyc(5);
        rst_n = 1'b1;
        rd(8'h26, 8'h83);
        rd(8'h27, 8'h84);
        rd(8'h28, 8'h00);
        rd(8'h2B, 8'h00);
        rd(8'h2E, 8'h00);
        rd(8'h34, 8'h01);
        wr(8'h25, 8'h00);
        rd(8'h25, 8'hA5);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        // slave setup interval at the reset low count
        cyc(1);
        setup_req = 1'b1;
        cyc(1);
        setup_req = 1'b0;
        `CHK("stretch on", 1'b1, scl_oe)
        span(1'b0, 1'b1, n);
        `CHK("setup cycles", 1320, n)
        `CHK("fast osc phase", 1'b1, (n * 5 * 20 / 26) >= 5000)
        // forward-channel loads drive the derived outputs
        remote_ser_model_inst.send_cfg(6'h3F);
        cyc(2);
        rd(8'h28, 8'h3F);
        `CHK("video active", 1'b0, vid)
        `CHK("sync video", 1'b1, syncv)
        `CHK("audio off", 1'b1, aoff)
        `CHK("surround", 1'b1, surr)
        remote_ser_model_inst.send_cfg(6'h10);
        cyc(2);
        rd(8'h28, 8'h10);
        `CHK("video active", 1'b1, vid)
        `CHK("auto dual", 1'b1, dual)
        `CHK("surround", 1'b0, surr)
        // hold bit keeps local values against later loads
        wr(8'h28, 8'hC5);
        remote_ser_model_inst.send_cfg(6'h3A);
        cyc(2);
        rd(8'h28, 8'h85);
        `CHK("surround", 1'b1, surr)
        `CHK("sync video", 1'b0, syncv)
        // every input mode, auto now sees a single link
        for (int m = 0; m < 4; m++) begin
            wr(8'h34, 8'(m << 3) | 8'hE7);
            cyc(2);
            rd(8'h34, 8'(m << 3) | 8'h01);
            `CHK("input mode", dual_exp[m], {sec, dual})
        end
        // alternate audio on the general pins, then disabled
        wr(8'h28, 8'h88);
        for (int k = 0; k < 2; k++) begin
            adata = k[0];
            word_clk = ~k[0];
            cyc(3);
            `CHK("pins", {2'b11, k[0], ~k[0]}, {p0_oe, p1_oe, p0_o, p1_o})
        end
        wr(8'h28, 8'h8C);
        cyc(2);
        `CHK("pins off", 4'h0, {p0_oe, p1_oe, p0_o, p1_o})
        // fifo error flags, clear, strobe edge
        cyc(1);
        ovr = 1'b1;
        cyc(1);
        ovr = 1'b0;
        und = 1'b1;
        cyc(1);
        und = 1'b0;
        rd(8'h2B, 8'h0C);
        wr(8'h2B, 8'hFF);
        rd(8'h2B, 8'h01);
        `CHK("rising edge", 1'b1, rise)
        wr(8'h2B, 8'hF0);
        rd(8'h2B, 8'h00);
        `CHK("rising edge", 1'b0, rise)
        // overrun in the same cycle as the clear: the set wins
        cyc(1);
        reg_req = {1'b1, 1'b0, 8'h2B, 8'h02};
        ovr = 1'b1;
        cyc(1);
        reg_req = '0;
        ovr = 1'b0;
        rd(8'h2B, 8'h08);
        wr(8'h2E, 8'hFF);
        rd(8'h2E, 8'h80);
        `CHK("test clock", 1'b1, pclk_ext)
        // a write while the clock enable is low must not land
        ce = 1'b0;
        wr(8'h2E, 8'h00);
        ce = 1'b1;
        rd(8'h2E, 8'h80);
        // master clock phases with short counts
        wr(8'h26, 8'h02);
        wr(8'h27, 8'h03);
        master_en = 1'b1;
        span(1'b0, 1'b0, n);
        span(1'b1, 1'b0, n);
        `CHK("low phase", 30, n)
        span(1'b0, 1'b0, hi);
        `CHK("high phase", 1'b1, hi >= 20 && hi <= 24)
        master_en = 1'b0;
        span(1'b1, 1'b0, n);
        cyc(40);
        `CHK("idle", 1'b0, scl_oe)
        `CHK("scl drive level", 1'b0, scl_o)
        test_done();
    end
endmodule
`default_nettype wire

/* deser_regs_defines.svh */
// register offsets, field positions, reset values and timing counts for the
// deserializer configuration bank; included by the package and design files
`ifndef DESER_REGS_DEFINES_SVH
`define DESER_REGS_DEFINES_SVH

// register offsets
`define REG_SELFTEST_ERR 8'h25
`define REG_SCL_HIGH 8'h26
`define REG_SCL_LOW 8'h27
`define REG_DPATH 8'h28
`define REG_AUDIO 8'h2B
`define REG_PCLK 8'h2E
`define REG_DUAL_RX 8'h34

// reset values
`define RST_SCL_HIGH 8'h83
`define RST_SCL_LOW 8'h84
`define RST_DPATH 8'h00
`define RST_AUDIO 8'h00
`define RST_PCLK 8'h00
`define RST_DUAL_RX 8'h01

// datapath config fields
`define DP_HOLD 7
`define DP_VIDEO_OFF 5
`define DP_DUAL_LINK 4
`define DP_ALT_AUDIO 3
`define DP_AUDIO_OFF 2
`define DP_SYNC_VIDEO 1
`define DP_SURROUND 0
`define DP_LOAD_MASK 8'h3F

// audio control fields
`define AU_OVERRUN 3
`define AU_UNDERRUN 2
`define AU_ERR_CLR 1
`define AU_RISE_EDGE 0

// pixel clock test and receive mode fields
`define PCLK_EXT 7
`define RX_MODE_HI 4
`define RX_MODE_LO 3

// timing: one count is 50 ns of nominal oscillator time
`define UNIT_NS 50
`define CLK_PERIOD_NS 5
`define UNIT_CYCLES ((`UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NOM_OSC_MHZ 20
`define FAST_OSC_MHZ 26
`define MIN_PHASE_NS 5000

`endif

/* deser_regs_pkg.sv */
// types shared by the deserializer configuration bank and its helpers
// assumes deser_regs_defines.svh is on the include path
package deser_regs_pkg;
    `include "deser_regs_defines.svh"

    // register access from the control-channel slave
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // datapath configuration sent by the remote serializer
    typedef struct packed {
        logic load;
        logic [5:0] bits;
    } fc_cfg_s;

    typedef enum logic [1:0] {
        RX_AUTO = 2'h0,
        RX_DUAL = 2'h1,
        RX_PRIMARY = 2'h2,
        RX_SECONDARY = 2'h3
    } rx_mode_e;

    // gray along idle -> high -> low -> high
    typedef enum logic [1:0] {
        SCL_IDLE = 2'h0,
        SCL_HIGH = 2'h1,
        SCL_LOW = 2'h3
    } scl_state_e;

    typedef logic [11:0] phase_t;
endpackage

/* phase_timer.sv */
// down-counter that times one clock phase of a given number of cycles
// assumes start is a one-cycle pulse from logic on ref_clk
`timescale 1ns/10ps
`default_nettype none
module phase_timer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire deser_regs_pkg::phase_t len,
    output logic busy,
    output logic expire
);
    import deser_regs_pkg::*;

    typedef struct packed {
        phase_t cnt;
        logic busy;
    } tmr_s;
    tmr_s st_r;
    tmr_s st_nxt;

    // expire marks the last cycle so the phase lasts exactly len cycles
    assign expire = st_r.busy && (st_r.cnt == 12'h001);
    assign busy = st_r.busy;

    // a zero length still gives one cycle
    always_comb begin
        st_nxt = st_r;
        if (start) begin
            st_nxt.cnt = (len == 12'h000) ? 12'h001 : len;
            st_nxt.busy = 1'b1;
        end else if (expire) begin
            st_nxt.cnt = 12'h000;
            st_nxt.busy = 1'b0;
        end else if (st_r.busy) begin
            st_nxt.cnt = st_r.cnt - 12'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

/* remote_ser_model.sv */
// behavioural model of the remote serializer side of the forward channel
// assumes the bench calls send_cfg from its main sequence on ref_clk
`timescale 1ns/10ps
`default_nettype none
module remote_ser_model (
    input wire logic ref_clk,
    output deser_regs_pkg::fc_cfg_s fc_cfg
);
    import deser_regs_pkg::*;

    initial begin
        fc_cfg = '0;
    end

    // datapath bits load
    // one load pulse per frame; bits scramble after the pulse so a late
    // sampler never sees a stale match
    task automatic send_cfg(input logic [5:0] b);
        @(posedge ref_clk);
        #1;
        fc_cfg = {1'b1, b};
        @(posedge ref_clk);
        #1;
        fc_cfg = {1'b0, ~b};
    endtask
endmodule
`default_nettype wire

/* sync2.sv */
// two-flop synchronizer for one level arriving from a pin
// assumes the input is asynchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module sync2 (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_s;
    sync_s st_r;
    sync_s st_nxt;

    // first stage feeds only the second
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule
`default_nettype wire
